// ---- verilog/apsdc_params.svh ----
// Purpose: constants of the access path select and domain check block
// Assumes: coprocessor register numbers select the registers
// Notes:   definitions only
`ifndef APSDC_PARAMS_SVH
`define APSDC_PARAMS_SVH

// coprocessor register numbers
`define APSDC_CRN_CTRL     4'h1
`define APSDC_CRN_TTB      4'h2
`define APSDC_CRN_DOMAIN   4'h3
`define APSDC_CRN_TCM      4'h9
// tcm region selector on the secondary opcode
`define APSDC_OP2_DTCM     3'h0
`define APSDC_OP2_ITCM     3'h1

// control register fields
`define APSDC_CTRL_MMU     0
`define APSDC_CTRL_DATA_CACHE  2
`define APSDC_CTRL_INSTRUCTION_CACHE  12
`define APSDC_CTRL_SEQEV   14
`define APSDC_CTRL_RST     1'h0

// table base pointer field
`define APSDC_TTB_LSB      14
`define APSDC_TTB_W        18
`define APSDC_TTB_RST      18'h0_0000

// domain register
`define APSDC_DOM_RST      32'h0000_0000
`define APSDC_DOM_NONE     2'h0
`define APSDC_DOM_CLIENT   2'h1
`define APSDC_DOM_RSVD     2'h2
`define APSDC_DOM_MANAGER  2'h3

// tcm region register fields
`define APSDC_TCM_EN       0
`define APSDC_TCM_SIZE_LSB 2
`define APSDC_TCM_BASE_LSB 12
`define APSDC_TCM_RST      32'h0000_0000
// region bytes are 2 ** (size code + this shift)
`define APSDC_TCM_SHIFT    6'h0c

`endif

// ---- verilog/apsdc_pkg.sv ----
// Purpose: types of the access path select and domain check block
// Assumes: nothing beyond the params header
// Notes:   structs carry one access and its answer
`default_nettype none

package apsdc_pkg;

  typedef enum logic [1:0] {
    APSDC_TO_AHB,
    APSDC_TO_CACHE,
    APSDC_TO_TCM
  } apsdc_route_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] virtual_address;
  } apsdc_req_s;

  // result of the table walk, supplied by the translation logic
  typedef struct packed {
    logic [31:0] physical_address;
    logic        cachable;
    logic        bufferable;
    logic [3:0]  domain;
    logic        perm_ok;
    logic        xlat_fault;
  } apsdc_xlat_s;

  typedef struct packed {
    logic         valid;
    apsdc_route_e route;
    logic [31:0]  physical_address;
    logic         cachable;
    logic         bufferable;
    logic         cache_lookup;
    logic         domain_fault;
    logic         perm_fault;
    logic         xlat_fault;
    logic         abort;
    logic         tcm_rd;
    logic         tcm_wr;
  } apsdc_rsp_s;

endpackage : apsdc_pkg

`default_nettype wire

// ---- verilog/apsdc_path_sel.sv ----
// Purpose: routes one side's accesses to cache, tcm or ahb and checks
// Assumes: translation result is valid in the cycle of the request
// Notes:   one instance per side, answer one cycle after the request
`include "apsdc_params.svh"
`default_nettype none

module apsdc_path_sel #(
  parameter bit IS_DATA = 1'b0
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 ce_i,
  // configuration
  input  wire logic                 mmu_en_i,
  input  wire logic                 cache_en_i,
  input  wire logic [31:0]          tcm_region_i,
  input  wire logic [1:0]           domain_code_i,
  // access
  input  wire apsdc_pkg::apsdc_req_s  req_i,
  input  wire apsdc_pkg::apsdc_xlat_s xlat_i,
  output var  apsdc_pkg::apsdc_rsp_s  rsp_o
);

  apsdc_pkg::apsdc_rsp_s rsp_ff;
  apsdc_pkg::apsdc_rsp_s nxt_rsp;
  logic [31:0]           addr;
  logic [5:0]            shamt;
  logic                  tcm_hit;

  //////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_rsp = '0;
    // flat mapping unless translation is on
    addr = mmu_en_i ? xlat_i.physical_address
                    : req_i.virtual_address;
    shamt = 6'(tcm_region_i[`APSDC_TCM_SIZE_LSB +: 4])
          + `APSDC_TCM_SHIFT;
    // region match on the bits above the region size
    tcm_hit = tcm_region_i[`APSDC_TCM_EN] &&
              (((addr ^ tcm_region_i) >> shamt) == 32'h0000_0000);
    nxt_rsp.valid = req_i.valid;
    nxt_rsp.physical_address = addr;
    if (req_i.valid && mmu_en_i)
    begin
      nxt_rsp.xlat_fault = xlat_i.xlat_fault;
      case (domain_code_i)
        `APSDC_DOM_NONE, `APSDC_DOM_RSVD:
          nxt_rsp.domain_fault = !xlat_i.xlat_fault;
        `APSDC_DOM_CLIENT:
          nxt_rsp.perm_fault = !xlat_i.xlat_fault &&
                               !xlat_i.perm_ok;
        default:
          nxt_rsp.perm_fault = 1'b0;
      endcase
    end
    nxt_rsp.abort = nxt_rsp.xlat_fault | nxt_rsp.domain_fault |
                    nxt_rsp.perm_fault;
    if (tcm_hit)
    begin
      nxt_rsp.route = apsdc_pkg::APSDC_TO_TCM;
      // reads go out even if they abort, writes never do
      nxt_rsp.tcm_rd = req_i.valid && !req_i.write;
      nxt_rsp.tcm_wr = req_i.valid && req_i.write &&
                       !nxt_rsp.abort;
    end
    else if (!cache_en_i)
    begin
      // a disabled cache is neither looked up nor changed
      nxt_rsp.route = apsdc_pkg::APSDC_TO_AHB;
    end
    else if (!mmu_en_i)
    begin
      if (IS_DATA)
      begin
        // data with translation off is uncached and unbuffered
        nxt_rsp.route = apsdc_pkg::APSDC_TO_AHB;
      end
      else
      begin
        nxt_rsp.route = apsdc_pkg::APSDC_TO_CACHE;
        nxt_rsp.cachable = 1'b1;
        nxt_rsp.cache_lookup = req_i.valid;
      end
    end
    else
    begin
      // page entry decides between cache and ahb
      nxt_rsp.cachable = xlat_i.cachable;
      nxt_rsp.bufferable = IS_DATA ? xlat_i.bufferable : 1'b0;
      nxt_rsp.route = xlat_i.cachable ? apsdc_pkg::APSDC_TO_CACHE
                                      : apsdc_pkg::APSDC_TO_AHB;
      nxt_rsp.cache_lookup = req_i.valid && !nxt_rsp.abort;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rsp_ff <= '0;
    else if (ce_i)
      rsp_ff <= nxt_rsp;
  end

  assign rsp_o = rsp_ff;

endmodule : apsdc_path_sel

`default_nettype wire

// ---- verilog/apsdc_top.sv ----
// Purpose: access path select, table base and domain checking
// Assumes: coprocessor transfers are single cycle, one at a time
// Notes:   routing answers come one cycle after the request
//
// Behaviour
// - instruction_cache off: every fetch goes to ahb, translation on or off.
// - instruction_cache on, translation off: fetches cachable, unchecked, flat address.
// - instruction_cache and translation on: page entry cacheability, checks, translation.
// - data_cache off: every data access goes to ahb.
// - data_cache on, translation off: data uncachable, unbufferable, flat.
// - data_cache and translation on: page entry attributes, checks, translation.
// - a disabled cache is never looked up nor modified.
// - itcm on, rest off: fetch tcm or ahb by region, flat, unchecked.
// - itcm and instruction_cache on, translation off: tcm or cache by region.
// - itcm, instruction_cache, translation on: tcm or cache/ahb, checked, translated.
// - dtcm on, rest off: data tcm or ahb by region, flat, unchecked.
// - dtcm and data_cache on, translation off: tcm or ahb, flat.
// - dtcm, data_cache, translation on: tcm or cache/ahb, checked, translated.
// - tcm reads may go out for aborted accesses; they are speculative.
// - an aborted write never reaches the tcm port.
// - table base reads give the pointer in the top eighteen bits.
// - table base writes load the top eighteen bits; low bits zero.
// - domain register holds sixteen two-bit fields, read and written whole.
// - field code 00 or 10 raises a domain fault on every translated access without a translation fault.
// - field code 01 checks the descriptor permission bits.
// - field code 11 skips permission checks; no permission fault.
// - translation bit 0, data_cache bit 2, instruction_cache bit 12, all reset low.
// - control bit 14 picks random or sequential eviction for both caches.
`include "apsdc_params.svh"
`default_nettype none

module apsdc_top (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   ce_i,
  // coprocessor register transfer
  input  wire logic                   cp_valid_i,
  input  wire logic                   cp_write_i,
  input  wire logic [3:0]             cp_crn_i,
  input  wire logic [2:0]             cp_op2_i,
  input  wire logic [31:0]            cp_wdata_i,
  output logic                        cp_rvalid_o,
  output logic [31:0]                 cp_rdata_o,
  // instruction side
  input  wire apsdc_pkg::apsdc_req_s  ifetch_req_i,
  input  wire apsdc_pkg::apsdc_xlat_s ifetch_xlat_i,
  output apsdc_pkg::apsdc_rsp_s       ifetch_rsp_o,
  // data side
  input  wire apsdc_pkg::apsdc_req_s  data_req_i,
  input  wire apsdc_pkg::apsdc_xlat_s data_xlat_i,
  output apsdc_pkg::apsdc_rsp_s       data_rsp_o,
  // state seen by the walker and the caches
  output logic [31:0]                 table_walk_base_o,
  output logic                        mmu_en_o,
  output logic                        sequential_evict_o
);

  //////////////////////////////////////////////////////////////////////
  // register file state
  logic                  mmu_en_ff;
  logic                  nxt_mmu_en;
  logic                  data_cache_en_ff;
  logic                  nxt_data_cache_en;
  logic                  instruction_cache_en_ff;
  logic                  nxt_instruction_cache_en;
  logic                  seq_evict_ff;
  logic                  nxt_seq_evict;
  logic [17:0]           table_walk_base_ff;
  logic [17:0]           nxt_table_walk_base;
  logic [31:0]           domain_fields_ff;
  logic [31:0]           nxt_domain_fields;
  logic [31:0]           dtcm_region_ff;
  logic [31:0]           nxt_dtcm_region;
  logic [31:0]           itcm_region_ff;
  logic [31:0]           nxt_itcm_region;
  logic                  cp_rvalid_ff;
  logic                  nxt_cp_rvalid;
  logic [31:0]           cp_rdata_ff;
  logic [31:0]           nxt_cp_rdata;
  logic                  wr;
  logic                  rd;
  logic [1:0]            icode;
  logic [1:0]            dcode;

  assign wr = cp_valid_i && cp_write_i;
  assign rd = cp_valid_i && !cp_write_i;

  //////////////////////////////////////////////////////////////////////
  // register writes
  always_comb
  begin
    nxt_mmu_en          = mmu_en_ff;
    nxt_data_cache_en       = data_cache_en_ff;
    nxt_instruction_cache_en       = instruction_cache_en_ff;
    nxt_seq_evict       = seq_evict_ff;
    nxt_table_walk_base = table_walk_base_ff;
    nxt_domain_fields   = domain_fields_ff;
    nxt_dtcm_region     = dtcm_region_ff;
    nxt_itcm_region     = itcm_region_ff;
    if (wr)
    begin
      case (cp_crn_i)
        `APSDC_CRN_CTRL:
        begin
          // only the translation, cache enable and eviction bits are held here
          nxt_mmu_en    = cp_wdata_i[`APSDC_CTRL_MMU];
          nxt_data_cache_en = cp_wdata_i[`APSDC_CTRL_DATA_CACHE];
          nxt_instruction_cache_en = cp_wdata_i[`APSDC_CTRL_INSTRUCTION_CACHE];
          nxt_seq_evict = cp_wdata_i[`APSDC_CTRL_SEQEV];
        end
        `APSDC_CRN_TTB:
          nxt_table_walk_base =
            cp_wdata_i[`APSDC_TTB_LSB +: `APSDC_TTB_W];
        `APSDC_CRN_DOMAIN:
          nxt_domain_fields = cp_wdata_i;
        `APSDC_CRN_TCM:
        begin
          if (cp_op2_i == `APSDC_OP2_DTCM)
            nxt_dtcm_region = cp_wdata_i;
          else if (cp_op2_i == `APSDC_OP2_ITCM)
            nxt_itcm_region = cp_wdata_i;
        end
        // other numbers, c4 among them, are ignored
        default:
          nxt_mmu_en = mmu_en_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mmu_en_ff          <= `APSDC_CTRL_RST;
      data_cache_en_ff       <= `APSDC_CTRL_RST;
      instruction_cache_en_ff       <= `APSDC_CTRL_RST;
      seq_evict_ff       <= `APSDC_CTRL_RST;
      table_walk_base_ff <= `APSDC_TTB_RST;
      domain_fields_ff   <= `APSDC_DOM_RST;
      dtcm_region_ff     <= `APSDC_TCM_RST;
      itcm_region_ff     <= `APSDC_TCM_RST;
    end
    else if (ce_i)
    begin
      mmu_en_ff          <= nxt_mmu_en;
      data_cache_en_ff       <= nxt_data_cache_en;
      instruction_cache_en_ff       <= nxt_instruction_cache_en;
      seq_evict_ff       <= nxt_seq_evict;
      table_walk_base_ff <= nxt_table_walk_base;
      domain_fields_ff   <= nxt_domain_fields;
      dtcm_region_ff     <= nxt_dtcm_region;
      itcm_region_ff     <= nxt_itcm_region;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register reads, answered one cycle later
  always_comb
  begin
    nxt_cp_rvalid = rd;
    nxt_cp_rdata  = 32'h0000_0000;
    if (rd)
    begin
      case (cp_crn_i)
        `APSDC_CRN_CTRL:
        begin
          nxt_cp_rdata[`APSDC_CTRL_MMU]    = mmu_en_ff;
          nxt_cp_rdata[`APSDC_CTRL_DATA_CACHE] = data_cache_en_ff;
          nxt_cp_rdata[`APSDC_CTRL_INSTRUCTION_CACHE] = instruction_cache_en_ff;
          nxt_cp_rdata[`APSDC_CTRL_SEQEV]  = seq_evict_ff;
        end
        // undefined low bits read as zero
        `APSDC_CRN_TTB:
          nxt_cp_rdata[`APSDC_TTB_LSB +: `APSDC_TTB_W] =
            table_walk_base_ff;
        `APSDC_CRN_DOMAIN:
          nxt_cp_rdata = domain_fields_ff;
        `APSDC_CRN_TCM:
        begin
          if (cp_op2_i == `APSDC_OP2_DTCM)
            nxt_cp_rdata = dtcm_region_ff;
          else if (cp_op2_i == `APSDC_OP2_ITCM)
            nxt_cp_rdata = itcm_region_ff;
        end
        default:
          nxt_cp_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cp_rvalid_ff <= 1'b0;
      cp_rdata_ff  <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      cp_rvalid_ff <= nxt_cp_rvalid;
      cp_rdata_ff  <= nxt_cp_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // domain field lookup; a new domain value takes effect on the next
  // access after the write edge, never part way through one
  assign icode = 2'(domain_fields_ff >> {ifetch_xlat_i.domain, 1'b0});
  assign dcode = 2'(domain_fields_ff >> {data_xlat_i.domain, 1'b0});

  //////////////////////////////////////////////////////////////////////
  // per side routing
  apsdc_path_sel #(
    .IS_DATA (1'b0)
  ) u_ifetch (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .ce_i          (ce_i),
    .mmu_en_i      (mmu_en_ff),
    .cache_en_i    (instruction_cache_en_ff),
    .tcm_region_i  (itcm_region_ff),
    .domain_code_i (icode),
    .req_i         (ifetch_req_i),
    .xlat_i        (ifetch_xlat_i),
    .rsp_o         (ifetch_rsp_o)
  );

  // the data cache is assumed clean by software before it is turned off
  apsdc_path_sel #(
    .IS_DATA (1'b1)
  ) u_data (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .ce_i          (ce_i),
    .mmu_en_i      (mmu_en_ff),
    .cache_en_i    (data_cache_en_ff),
    .tcm_region_i  (dtcm_region_ff),
    .domain_code_i (dcode),
    .req_i         (data_req_i),
    .xlat_i        (data_xlat_i),
    .rsp_o         (data_rsp_o)
  );

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign cp_rvalid_o        = cp_rvalid_ff;
  assign cp_rdata_o         = cp_rdata_ff;
  assign table_walk_base_o  = {table_walk_base_ff, 14'h0000};
  assign mmu_en_o           = mmu_en_ff;
  assign sequential_evict_o = seq_evict_ff;

endmodule : apsdc_top

`default_nettype wire

// ---- tb/apsdc_walk_model.sv ----
// Purpose: table walk result for one access side
// Assumes: attributes are read straight from address bits
// Notes:   stateless, so speculative tcm reads have no side effect
`default_nettype none

module apsdc_walk_model (
  // access seen
  input  wire apsdc_pkg::apsdc_req_s req_i,
  // walk result
  output var  apsdc_pkg::apsdc_xlat_s xlat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  apsdc_pkg::apsdc_xlat_s res;

  // bit 30 flips; bits 23:16 give fault, perm, attributes, domain
  always_comb
  begin
    res.physical_address = req_i.virtual_address ^ 32'h4000_0000;
    res.xlat_fault       = req_i.virtual_address[23];
    res.perm_ok          = req_i.virtual_address[22];
    res.bufferable       = req_i.virtual_address[21];
    res.cachable         = req_i.virtual_address[20];
    res.domain           = req_i.virtual_address[19:16];
  end
  // idle result is inverted so a stale value never passes
  assign xlat_o = req_i.valid ? res : ~res;
endmodule : apsdc_walk_model

`default_nettype wire

// ---- tb/apsdc_top_chk.sv ----
// Purpose: port level checks of the path select block
// Assumes: one clock domain
// Notes:   attached by bind
`include "apsdc_params.svh"
`default_nettype none

module apsdc_top_chk (
  input wire logic                  clk_i,
  input wire logic                  arst_n_i,
  input wire logic                  ce_i,
  input wire logic                  cp_valid_i,
  input wire logic                  cp_write_i,
  input wire logic [3:0]            cp_crn_i,
  input wire logic [31:0]           cp_wdata_i,
  input wire logic                  cp_rvalid_o,
  input wire logic [31:0]           cp_rdata_o,
  input wire apsdc_pkg::apsdc_req_s ifetch_req_i,
  input wire apsdc_pkg::apsdc_rsp_s ifetch_rsp_o,
  input wire apsdc_pkg::apsdc_req_s data_req_i,
  input wire apsdc_pkg::apsdc_xlat_s data_xlat_i,
  input wire apsdc_pkg::apsdc_rsp_s data_rsp_o,
  input wire logic [31:0]           table_walk_base_o,
  input wire logic                  mmu_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic rd_ok;
  assign rd_ok = ce_i && cp_valid_i && !cp_write_i;
  // shadow of the instruction_cache enable, followed from control writes
  logic ic_on_ff;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ic_on_ff <= 1'b0;
    else if (ce_i && cp_valid_i && cp_write_i &&
             cp_crn_i == `APSDC_CRN_CTRL)
      ic_on_ff <= cp_wdata_i[`APSDC_CTRL_INSTRUCTION_CACHE];
  end

  property p_rd_ans;
    ce_i |=> cp_rvalid_o == $past(rd_ok);
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read strobe wrong");
  property p_ttb_rd;
    rd_ok && cp_crn_i == `APSDC_CRN_TTB |=>
      cp_rdata_o == $past(table_walk_base_o);
  endproperty
  a_ttb_rd: assert property (p_ttb_rd) else $error("base read wrong");
  property p_ttb_low;
    table_walk_base_o[13:0] == 14'h0000;
  endproperty
  a_ttb_low: assert property (p_ttb_low) else $error("base low set");
  property p_ttb_wr;
    ce_i && cp_valid_i && cp_write_i && cp_crn_i == `APSDC_CRN_TTB |=>
      table_walk_base_o[31:14] == $past(cp_wdata_i[31:14]);
  endproperty
  a_ttb_wr: assert property (p_ttb_wr) else $error("base write lost");
  property p_i_flat;
    ce_i && ifetch_req_i.valid && !mmu_en_o |=> !ifetch_rsp_o.abort &&
      ifetch_rsp_o.physical_address == $past(ifetch_req_i.virtual_address);
  endproperty
  a_i_flat: assert property (p_i_flat) else $error("fetch not flat");
  property p_d_flat;
    ce_i && data_req_i.valid && !mmu_en_o |=> !data_rsp_o.abort &&
      data_rsp_o.physical_address == $past(data_req_i.virtual_address);
  endproperty
  a_d_flat: assert property (p_d_flat) else $error("data not flat");
  property p_d_xlat;
    ce_i && data_req_i.valid && mmu_en_o |=>
      data_rsp_o.physical_address == $past(data_xlat_i.physical_address);
  endproperty
  a_d_xlat: assert property (p_d_xlat) else $error("data not mapped");
  property p_tcm_wr;
    data_rsp_o.tcm_wr |-> !data_rsp_o.abort &&
      data_rsp_o.route == apsdc_pkg::APSDC_TO_TCM;
  endproperty
  a_tcm_wr: assert property (p_tcm_wr) else $error("aborted tcm write");
  // uncachable fetches with the cache on may still look it up
  property p_ahb_look;
    ce_i && !ic_on_ff |=> !ifetch_rsp_o.cache_lookup;
  endproperty
  a_ahb_look: assert property (p_ahb_look) else $error("stray lookup");

  c_dom: cover property (data_rsp_o.domain_fault);
  c_spec: cover property (data_rsp_o.tcm_rd && data_rsp_o.abort);
  c_rd: cover property (cp_rvalid_o);
endmodule : apsdc_top_chk

bind apsdc_top apsdc_top_chk chk_u (.clk_i, .arst_n_i, .ce_i, .cp_valid_i,
  .cp_write_i, .cp_crn_i, .cp_wdata_i, .cp_rvalid_o, .cp_rdata_o,
  .ifetch_req_i, .ifetch_rsp_o, .data_req_i, .data_xlat_i, .data_rsp_o,
  .table_walk_base_o, .mmu_en_o);

`default_nettype wire

// ---- tb/apsdc_top_test.sv ----
// Purpose: directed scenarios for the path select block
// Assumes: walk model gives attributes from address bits
// Notes:   inputs change on the falling edge
`default_nettype none

module apsdc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk_i, arst_n_i, ce_i, cp_valid_i, cp_write_i;
  logic [3:0]             cp_crn_i;
  logic [2:0]             cp_op2_i;
  logic [31:0]            cp_wdata_i, cp_rdata_o, table_walk_base_o;
  logic                   cp_rvalid_o, mmu_en_o, sequential_evict_o;
  apsdc_pkg::apsdc_req_s  ifetch_req_i, data_req_i;
  apsdc_pkg::apsdc_xlat_s ifetch_xlat_i, data_xlat_i;
  apsdc_pkg::apsdc_rsp_s  ifetch_rsp_o, data_rsp_o;
  int                     n_mismatch = 0;
  int                     cmp_count = 0;

  apsdc_top dut_u (.clk_i, .arst_n_i, .ce_i, .cp_valid_i, .cp_write_i,
    .cp_crn_i, .cp_op2_i, .cp_wdata_i, .cp_rvalid_o, .cp_rdata_o,
    .ifetch_req_i, .ifetch_xlat_i, .ifetch_rsp_o, .data_req_i,
    .data_xlat_i, .data_rsp_o, .table_walk_base_o, .mmu_en_o,
    .sequential_evict_o);
  apsdc_walk_model iwalk_u (.req_i(ifetch_req_i), .xlat_o(ifetch_xlat_i));
  apsdc_walk_model dwalk_u (.req_i(data_req_i), .xlat_o(data_xlat_i));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cp(input logic wr, input logic [3:0] crn,
                    input logic [2:0] op2, input logic [31:0] d);
    @(negedge clk_i);
    cp_valid_i = 1'b1;
    cp_write_i = wr;
    cp_crn_i   = crn;
    cp_op2_i   = op2;
    cp_wdata_i = d;
    @(negedge clk_i);
    cp_valid_i = 1'b0;
  endtask : cp

  // flags packed as route,c,b,lookup,dom,perm,xlat,abort,rd,wr,valid
  task automatic acc(input bit d, input logic wr, input logic [31:0] va,
                     input logic [11:0] m, input logic [11:0] e,
                     input logic [31:0] pa);
    apsdc_pkg::apsdc_rsp_s r;
    @(negedge clk_i);
    if (d)
      data_req_i = '{1'b1, wr, va};
    else
      ifetch_req_i = '{1'b1, wr, va};
    @(negedge clk_i);
    data_req_i.valid = 1'b0;
    ifetch_req_i.valid = 1'b0;
    r = d ? data_rsp_o : ifetch_rsp_o;
    chk({20'h0_0000, m & {r.route, r.cachable, r.bufferable,
        r.cache_lookup, r.domain_fault, r.perm_fault, r.xlat_fault,
        r.abort, r.tcm_rd, r.tcm_wr, r.valid}}, {20'h0_0000, e});
    chk(r.physical_address, pa);
  endtask : acc

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk({29'h0000_0000, mmu_en_o, sequential_evict_o, cp_rvalid_o}, 0);
    cp(0, 4'h1, 3'h0, 32'h0000_0000);
    chk(cp_rdata_o, 32'h0000_0000);
    cp(1, 4'h1, 3'h0, 32'hFFFF_FFFF);
    cp(0, 4'h1, 3'h0, 32'h0000_0000);
    chk(cp_rdata_o, 32'h0000_5005);
    chk({30'h0000_0000, mmu_en_o, sequential_evict_o}, 32'h0000_0003);
    cp(1, 4'h2, 3'h0, 32'h1234_7FFF);
    chk(table_walk_base_o, 32'h1234_4000);
    cp(0, 4'h2, 3'h0, 32'h0000_0000);
    chk(cp_rdata_o, 32'h1234_4000);
    cp(1, 4'h3, 3'h0, 32'hA5C3_0F96);
    cp(0, 4'h3, 3'h0, 32'h0000_0000);
    chk(cp_rdata_o, 32'hA5C3_0F96);
    cp(0, 4'h4, 3'h0, 32'h0000_0000);
    chk({cp_rvalid_o, cp_rdata_o[30:0]}, 32'h8000_0000);
    // no data was ever cached, so nothing to clean first
    cp(1, 4'h1, 3'h0, 32'h0000_0000);
    ce_i = 1'b0;
    cp(0, 4'h3, 3'h0, 32'h0000_0000);
    chk({31'h0000_0000, cp_rvalid_o}, 32'h0000_0000);
    ce_i = 1'b1;
    $display("registers done");
  endtask : t_regs

  task automatic t_route;
    logic [11:0] ex [4] = '{12'h749, 12'h729, 12'h749, 12'h781};
    cp(1, 4'h3, 3'h0, 32'hFFFF_FFFF);
    acc(0, 0, 32'h0001_0000, 12'hFFF, 12'h001, 32'h0001_0000);
    acc(1, 1, 32'h0001_0000, 12'hFFF, 12'h001, 32'h0001_0000);
    cp(1, 4'h1, 3'h0, 32'h0000_0001);
    acc(0, 0, 32'h0001_0000, 12'hFFF, 12'h001, 32'h4001_0000);
    acc(1, 0, 32'h0001_0000, 12'hFFF, 12'h001, 32'h4001_0000);
    cp(1, 4'h1, 3'h0, 32'h0000_1004);
    acc(0, 0, 32'h00F0_1234, 12'hFFF, 12'h681, 32'h00F0_1234);
    acc(1, 0, 32'h00F0_1234, 12'hFFF, 12'h001, 32'h00F0_1234);
    cp(1, 4'h1, 3'h0, 32'h0000_1005);
    for (int c = 0; c < 4; c++)
    begin
      cp(1, 4'h3, 3'h0, 32'(c) << 10);
      acc(1, 0, 32'h0035_0000, 12'hFFF, ex[c], 32'h4035_0000);
    end
    acc(0, 0, 32'h0035_0000, 12'hFFF, 12'h681, 32'h4035_0000);
    acc(1, 0, 32'h0005_0000, 12'hFFF, 12'h081, 32'h4005_0000);
    cp(1, 4'h3, 3'h0, 32'h0000_0000);
    acc(1, 0, 32'h00B5_0000, 12'hFFF, 12'h719, 32'h40B5_0000);
    $display("routing done");
  endtask : t_route

  task automatic t_tcm;
    cp(1, 4'h1, 3'h0, 32'h0000_0000);
    cp(1, 4'h9, 3'h0, 32'h0010_0001);
    acc(1, 0, 32'h0010_0FFC, 12'hC07, 12'h805, 32'h0010_0FFC);
    acc(1, 0, 32'h0010_1000, 12'hFFF, 12'h001, 32'h0010_1000);
    acc(1, 1, 32'h0010_0000, 12'hC07, 12'h803, 32'h0010_0000);
    cp(1, 4'h1, 3'h0, 32'h0000_0004);
    acc(1, 0, 32'h0010_0010, 12'hC07, 12'h805, 32'h0010_0010);
    cp(1, 4'h9, 3'h1, 32'h0020_0001);
    cp(1, 4'h1, 3'h0, 32'h0000_0000);
    acc(0, 0, 32'h0020_0004, 12'hC07, 12'h805, 32'h0020_0004);
    cp(1, 4'h1, 3'h0, 32'h0000_1000);
    acc(0, 0, 32'h0020_0008, 12'hC07, 12'h805, 32'h0020_0008);
    acc(0, 0, 32'h0030_0000, 12'hFFF, 12'h681, 32'h0030_0000);
    cp(1, 4'h1, 3'h0, 32'h0000_1005);
    cp(1, 4'h9, 3'h0, 32'h4010_0001);
    acc(1, 1, 32'h0010_0800, 12'hC0F, 12'h809, 32'h4010_0800);
    acc(1, 0, 32'h0010_0800, 12'hC0F, 12'h80D, 32'h4010_0800);
    cp(1, 4'h9, 3'h1, 32'h4020_0001);
    cp(1, 4'h3, 3'h0, 32'hFFFF_FFFF);
    acc(0, 0, 32'h0020_0000, 12'hC0F, 12'h805, 32'h4020_0000);
    $display("tcm done");
  endtask : t_tcm

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    finish_test;
  end

  initial
  begin
    arst_n_i     = 1'b0;
    ce_i         = 1'b1;
    cp_valid_i   = 1'b0;
    cp_write_i   = 1'b0;
    cp_crn_i     = 4'h0;
    cp_op2_i     = 3'h0;
    cp_wdata_i   = 32'h0000_0000;
    ifetch_req_i = '0;
    data_req_i   = '0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'b1;
    t_regs;
    t_route;
    t_tcm;
    finish_test;
  end
endmodule : apsdc_top_test

`default_nettype wire
